// ---- logic/lcdcd_pkg.sv ----
// Purpose: constants and types for the LCD command decoder
// Assumes: host bytes arrive already deserialised, one per strobe
// Notes:   Operation list below
`default_nettype none
package lcdcd_pkg;
	localparam int COLS = 128;
	localparam int PAGES = 8;
	localparam logic [6:0] COL_LAST = 7'h7f;
	localparam logic [2:0] PAGE_LAST = 3'h7;
	// opcodes
	localparam logic [7:0] OP_WRITE = 8'h01;
	localparam logic [7:0] OP_READ = 8'h02;
	localparam logic [7:0] OP_STATUS = 8'h03;
	localparam logic [7:0] OP_COL = 8'h04;
	localparam logic [7:0] OP_VEND_ADV = 8'h30;
	localparam logic [7:0] OP_CONTRAST = 8'h81;
	localparam logic [7:0] OP_TRIPLE = 8'h82;
	localparam logic [7:0] OP_SCAN_DIV = 8'h83;
	localparam logic [7:0] OP_DISP = 8'hc9;
	localparam logic [7:0] OP_SYSRST = 8'he1;
	localparam logic [7:0] OP_NOP = 8'he3;
	localparam logic [7:0] OP_LAST_ROW = 8'hf1;
	localparam logic [6:0] OP_VEND_TEST_HI = 7'h72;
	localparam logic [5:0] OP_TEMP_HI = 6'h09;
	localparam logic [4:0] OP_PUMP_HI = 5'h05;
	localparam logic [4:0] OP_PAGE_HI = 5'h16;
	localparam logic [3:0] OP_PANEL_HI = 4'ha;
	localparam logic [5:0] OP_BIAS_HI = 6'h3a;
	localparam logic [6:0] DISP_KEY = 7'h57;
	localparam logic [7:0] SYSRST_KEY = 8'he2;
	localparam logic [7:0] SEL_LINE = 8'h00;
	localparam logic [7:0] SEL_ISO_FRONT = 8'h01;
	localparam logic [7:0] SEL_ISO_END = 8'h02;
	// reset values
	localparam logic [1:0] BIAS_RST = 2'h2;
	localparam logic [1:0] TEMP_RST = 2'h0;
	localparam logic [6:0] CONTRAST_RST = 7'h6e;
	localparam logic [2:0] PUMP_RST = 3'h5;
	localparam logic [3:0] PANEL_RST = 4'h2;
	localparam logic [4:0] DIV_RST = 5'h06;
	localparam logic [6:0] LINE_RST = 7'h16;
	localparam logic [2:0] ISO_FRONT_RST = 3'h1;
	localparam logic [2:0] ISO_END_RST = 3'h0;
	localparam logic [5:0] LAST_ROW_RST = 6'h3f;
	// field positions
	localparam int COL_MIRROR_BIT = 2;
	localparam int ROW_MIRROR_BIT = 3;
	localparam int STEP_WRAP_BIT = 0;
	localparam int STEP_COL_DOWN_BIT = 1;
	localparam int STEP_PAGE_DOWN_BIT = 2;
	localparam int FIFO_DEPTH = 8;
	localparam int POWER_UP_CYC = 4;

	typedef enum logic [2:0] {
		LCDCD_IDLE = 3'b000,
		LCDCD_WR   = 3'b001,
		LCDCD_RD   = 3'b011,
		LCDCD_STAT = 3'b010,
		LCDCD_PARM = 3'b110,
		LCDCD_SEL  = 3'b111,
		LCDCD_VAL  = 3'b101
	} lcdcd_state_t;

	typedef struct packed {
		logic       cmd_or_pixel_select;
		logic [7:0] data;
	} lcdcd_tok_t;

	typedef struct packed {
		logic [1:0] bias_ratio_select;
		logic [1:0] temp_coef_select;
		logic [6:0] contrast_level;
		logic [2:0] pump_config;
		logic [3:0] panel_control;
		logic [4:0] scan_clock_divider;
		logic [6:0] line_width_clocks;
		logic [2:0] isolation_front_clocks;
		logic [2:0] isolation_end_clocks;
		logic [5:0] last_row_index;
	} lcdcd_cfg_t;

	typedef struct packed {
		logic       we;
		logic [2:0] page;
		logic [6:0] col;
		logic [7:0] wdata;
	} lcdcd_ram_t;

	localparam lcdcd_cfg_t CFG_RST = '{BIAS_RST, TEMP_RST, CONTRAST_RST, PUMP_RST,
		PANEL_RST, DIV_RST, LINE_RST, ISO_FRONT_RST, ISO_END_RST, LAST_ROW_RST};
endpackage
`default_nettype wire

// ---- logic/lcdcd_fifo.sv ----
// Purpose: token FIFO between host byte receiver and decoder
// Assumes: single clock, flip-flop storage
// Notes:   full/empty from an occupancy count
`default_nettype none
module lcdcd_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	input  wire logic         clk,     // clock
	input  wire logic         rst,     // async reset
	input  wire logic [W-1:0] in_data, // fill data
	input  wire logic         in_valid, // fill valid
	output logic              in_ready, // not full
	output logic [W-1:0]      out_data, // head word
	output logic              out_valid, // not empty
	input  wire logic         out_ready // drain accept
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign out_valid = (cnt_q != '0);
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem_q[rp_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b1;
		end else begin
			// registered so the top's ready output comes from a flip-flop
			in_ready <= (cnt_d != D[AW:0]);
			if (push) begin
				wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_d;
		end
	end
endmodule
`default_nettype wire

// ---- logic/lcdcd_top.sv ----
// Purpose: command decoder and control register bank of the LCD controller
// Assumes: host bytes arrive as tokens with a command/data select bit
// Notes:   RAM itself sits outside; this block drives its port
`default_nettype none
module lcdcd_top (
	input  wire logic                  CLK,        // master clock
	input  wire logic                  RST,        // power-up or pin reset
	input  wire lcdcd_pkg::lcdcd_tok_t TOK,        // host token
	input  wire logic                  TOK_VALID,  // token strobe
	output logic                       TOK_READY,  // FIFO has room
	input  wire logic [2:0]            PTR_STEP,   // pointer-step config bits
	input  wire logic                  SILICON_VERSION, // version strap
	input  wire logic [7:0]            RAM_RDATA,  // RAM read data, next cycle
	output lcdcd_pkg::lcdcd_ram_t      RAM_REQ,    // RAM access
	output logic                       RAM_RE,     // RAM read strobe
	output logic [7:0]                 RD_DATA,    // byte returned to host
	output logic                       RD_VALID,   // read byte pulse
	output lcdcd_pkg::lcdcd_cfg_t      CFG,        // control registers
	output logic                       DISPLAY_ON, // display on/off bit
	output logic                       DRIVERS_ON, // drivers active
	output logic                       SLEEP       // sleep mode
);
	import lcdcd_pkg::*;

	lcdcd_tok_t   tok;
	logic         tok_valid, tok_take;
	lcdcd_state_t state_q;
	logic [7:0]   op_q, sel_q;
	logic [6:0]   column_pointer_q;
	logic [2:0]   row_group_index_q;
	lcdcd_cfg_t   cfg_q;
	logic         display_on_bit_q, drivers_on_q, sleep_q;
	logic [2:0]   pwr_cnt_q;
	logic         rd_pend_q;
	logic         is_cmd, is_data, soft_rst, ram_step;

	lcdcd_fifo #(.W($bits(lcdcd_tok_t)), .D(FIFO_DEPTH)) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_data(TOK),
		.in_valid(TOK_VALID),
		.in_ready(TOK_READY),
		.out_data(tok),
		.out_valid(tok_valid),
		.out_ready(tok_take)
	);

	// stall decode while a read result is pending so the RAM port stays single
	assign tok_take = !rd_pend_q;
	assign is_cmd = tok_valid && tok_take && !tok.cmd_or_pixel_select;
	assign is_data = tok_valid && tok_take && tok.cmd_or_pixel_select;
	assign soft_rst = is_data && state_q == LCDCD_PARM && op_q == OP_SYSRST
		&& tok.data == SYSRST_KEY;
	assign ram_step = is_data && (state_q == LCDCD_WR || state_q == LCDCD_RD);

	// ==========================================================
	// helpers
	function automatic logic [6:0] ram_col(input logic [6:0] c, input logic mx);
		ram_col = mx ? (COL_LAST - c) : c;
	endfunction

	function automatic logic two_byte(input logic [7:0] op);
		two_byte = op == OP_COL || op == OP_VEND_ADV || op == OP_CONTRAST
			|| op == OP_SCAN_DIV || op == OP_DISP || op == OP_SYSRST || op == OP_LAST_ROW
			|| op[7:1] == OP_VEND_TEST_HI;
	endfunction

	// ==========================================================
	// sequence state
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= LCDCD_IDLE;
			op_q <= 8'h00;
			sel_q <= 8'h00;
		end else if (is_cmd) begin
			op_q <= tok.data;
			case (tok.data)
				OP_WRITE: state_q <= LCDCD_WR;
				OP_READ: state_q <= LCDCD_RD;
				OP_STATUS: state_q <= LCDCD_STAT;
				OP_TRIPLE: state_q <= LCDCD_SEL;
				default: state_q <= two_byte(tok.data) ? LCDCD_PARM : LCDCD_IDLE;
			endcase
		end else if (is_data) begin
			case (state_q)
				LCDCD_SEL: begin
					sel_q <= tok.data;
					state_q <= LCDCD_VAL;
				end
				default: state_q <= LCDCD_IDLE;
			endcase
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cfg_q <= CFG_RST;
			display_on_bit_q <= 1'b0;
		end else if (soft_rst) begin
			cfg_q <= CFG_RST;
			display_on_bit_q <= 1'b0;
		end else if (is_cmd) begin
			if (tok.data[7:2] == OP_TEMP_HI) begin
				cfg_q.temp_coef_select <= tok.data[1:0];
			end
			if (tok.data[7:3] == OP_PUMP_HI) begin
				cfg_q.pump_config <= tok.data[2:0];
			end
			if (tok.data[7:4] == OP_PANEL_HI) begin
				cfg_q.panel_control <= tok.data[3:0];
			end
			if (tok.data[7:2] == OP_BIAS_HI) begin
				cfg_q.bias_ratio_select <= tok.data[1:0];
			end
		end else if (is_data && state_q == LCDCD_PARM) begin
			case (op_q)
				OP_CONTRAST: cfg_q.contrast_level <= tok.data[6:0];
				OP_SCAN_DIV: cfg_q.scan_clock_divider <= tok.data[4:0];
				OP_LAST_ROW: cfg_q.last_row_index <= tok.data[5:0];
				OP_DISP: begin
					if (tok.data[7:1] == DISP_KEY) begin
						display_on_bit_q <= tok.data[0];
					end
				end
				default: ; // vendor parameters are swallowed
			endcase
		end else if (is_data && state_q == LCDCD_VAL) begin
			case (sel_q)
				SEL_LINE: cfg_q.line_width_clocks <= tok.data[6:0];
				SEL_ISO_FRONT: cfg_q.isolation_front_clocks <= tok.data[2:0];
				SEL_ISO_END: cfg_q.isolation_end_clocks <= tok.data[2:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// RAM pointers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			column_pointer_q <= 7'h00;
			row_group_index_q <= 3'h0;
		end else if (soft_rst) begin
			column_pointer_q <= 7'h00;
			row_group_index_q <= 3'h0;
		end else if (is_cmd && tok.data[7:3] == OP_PAGE_HI) begin
			row_group_index_q <= tok.data[2:0];
		end else if (is_data && state_q == LCDCD_PARM && op_q == OP_COL) begin
			column_pointer_q <= tok.data[6:0];
		end else if (ram_step) begin
			if (!PTR_STEP[STEP_COL_DOWN_BIT]) begin
				if (column_pointer_q != COL_LAST) begin
					column_pointer_q <= column_pointer_q + 7'h01;
				end else if (PTR_STEP[STEP_WRAP_BIT]) begin
					column_pointer_q <= 7'h00;
					row_group_index_q <= PTR_STEP[STEP_PAGE_DOWN_BIT] ? row_group_index_q - 3'h1
						: row_group_index_q + 3'h1;
				end // else hold at page end
			end else begin
				if (column_pointer_q != 7'h00) begin
					column_pointer_q <= column_pointer_q - 7'h01;
				end else if (PTR_STEP[STEP_WRAP_BIT]) begin
					column_pointer_q <= COL_LAST;
					row_group_index_q <= PTR_STEP[STEP_PAGE_DOWN_BIT] ? row_group_index_q - 3'h1
						: row_group_index_q + 3'h1;
				end
			end
		end
	end

	// ==========================================================
	// RAM port and read answers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			RAM_REQ <= '0;
			RAM_RE <= 1'b0;
			rd_pend_q <= 1'b0;
			RD_DATA <= 8'h00;
			RD_VALID <= 1'b0;
		end else begin
			RAM_REQ.we <= ram_step && state_q == LCDCD_WR;
			RAM_REQ.page <= row_group_index_q;
			RAM_REQ.col <= ram_col(column_pointer_q, cfg_q.panel_control[COL_MIRROR_BIT]);
			RAM_REQ.wdata <= tok.data;
			RAM_RE <= ram_step && state_q == LCDCD_RD;
			rd_pend_q <= ram_step && state_q == LCDCD_RD;
			RD_VALID <= 1'b0;
			if (rd_pend_q) begin
				RD_DATA <= RAM_RDATA;
				RD_VALID <= 1'b1;
			end else if (is_data && state_q == LCDCD_STAT) begin
				RD_DATA <= {SILICON_VERSION, drivers_on_q, cfg_q.panel_control[COL_MIRROR_BIT],
					cfg_q.panel_control[ROW_MIRROR_BIT], 4'h0};
				RD_VALID <= 1'b1;
			end
		end
	end

	// ==========================================================
	// sleep and driver sequencing: power first, drivers after
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sleep_q <= 1'b1;
			drivers_on_q <= 1'b0;
			pwr_cnt_q <= 3'h0;
		end else if (!display_on_bit_q) begin
			sleep_q <= 1'b1;
			drivers_on_q <= 1'b0;
			pwr_cnt_q <= 3'h0;
		end else begin
			sleep_q <= 1'b0;
			if (pwr_cnt_q != 3'(POWER_UP_CYC)) begin
				pwr_cnt_q <= pwr_cnt_q + 3'h1;
			end else begin
				drivers_on_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CFG <= CFG_RST;
			DISPLAY_ON <= 1'b0;
			DRIVERS_ON <= 1'b0;
			SLEEP <= 1'b1;
		end else begin
			CFG <= cfg_q;
			DISPLAY_ON <= display_on_bit_q;
			DRIVERS_ON <= drivers_on_q;
			SLEEP <= sleep_q;
		end
	end
endmodule
`default_nettype wire

// ---- dv/lcdcd_checker.sv ----
// Purpose: port assertions for the LCD command decoder
// Assumes: one clock, RST async active high
// Notes:   bound to the top from the bench file
`default_nettype none
module lcdcd_checker
	import lcdcd_pkg::*;
(
	input wire logic                  CLK,        // clock
	input wire logic                  RST,        // reset
	input wire logic                  TOK_VALID,  // token strobe
	input wire lcdcd_pkg::lcdcd_ram_t RAM_REQ,    // ram access
	input wire logic                  RAM_RE,     // ram read
	input wire logic                  RD_VALID,   // read pulse
	input wire lcdcd_pkg::lcdcd_cfg_t CFG,        // registers
	input wire logic                  DISPLAY_ON, // display bit
	input wire logic                  DRIVERS_ON, // drivers active
	input wire logic                  SLEEP       // sleep mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// ==========
	// power sequencing
	sequence power_up_s;
		!DRIVERS_ON [*3] ##[1:3] DRIVERS_ON;
	endsequence
	sequence power_down_s;
		##[0:1] (!DRIVERS_ON && SLEEP);
	endsequence
	reset_defaults_a: assert property ($fell(RST) |-> CFG == CFG_RST && SLEEP &&
		!DISPLAY_ON)
		else $error("registers not at defaults after reset");
	read_answer_a: assert property (RAM_RE |=> RD_VALID)
		else $error("read byte missing after ram read");
	read_pulse_a: assert property (RD_VALID |=> !RD_VALID)
		else $error("read pulse longer than one cycle");
	write_once_a: assert property (RAM_REQ.we |=> !RAM_REQ.we && !RAM_RE)
		else $error("second ram access from one byte");
	power_up_a: assert property ($rose(DISPLAY_ON) |-> power_up_s)
		else $error("drivers not enabled after power up");
	drivers_gate_a: assert property ($rose(DRIVERS_ON) |-> DISPLAY_ON && !SLEEP)
		else $error("drivers enabled while asleep");
	power_down_a: assert property ($fell(DISPLAY_ON) |-> power_down_s)
		else $error("drivers not idled on display off");
	// a drained queue must leave the registers alone
	cfg_quiet_a: assert property (!TOK_VALID [*8] |=> $stable(CFG))
		else $error("registers changed without tokens");
endmodule
`default_nettype wire

// ---- dv/lcdcd_ram_model.sv ----
// Purpose: display RAM beside the decoder's RAM port
// Assumes: read data stands while the read strobe is high
// Notes:   no reset, contents survive every reset
`default_nettype none
module lcdcd_ram_model
	import lcdcd_pkg::*;
(
	input wire logic                  clk,   // clock
	input wire lcdcd_pkg::lcdcd_ram_t req,   // access
	input wire logic                  re,    // read strobe
	output logic [7:0]                rdata  // read data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [PAGES][COLS];
	always_ff @(posedge clk) begin
		if (req.we)
			mem[req.page][req.col] <= req.wdata;
	end
	// decoder latches at the edge closing the strobe cycle; otherwise the inverse
	always_comb begin
		if (re)
			rdata = mem[req.page][req.col];
		else
			rdata = ~mem[req.page][req.col];
	end
endmodule
`default_nettype wire

// ---- dv/lcdcd_test.sv ----
// Purpose: self-checking bench for the LCD command decoder
// Assumes: host tokens given whole, one per handshake
// Notes:   register rows in a table, ram and power cases by hand
`default_nettype none
module lcdcd_test
	import lcdcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK, RST, TOK_VALID, TOK_READY, SILICON_VERSION, RAM_RE, RD_VALID;
	logic DISPLAY_ON, DRIVERS_ON, SLEEP, full_seen;
	logic [2:0] PTR_STEP;
	logic [7:0] RAM_RDATA, RD_DATA, rd_last, n, b0, b1, b2, f, v;
	lcdcd_tok_t TOK;
	lcdcd_ram_t RAM_REQ;
	lcdcd_cfg_t CFG, prev;
	int mismatches, checks_done, rd_cnt, base;
	logic [47:0] rows [11] = '{ // no vendor opcodes sent
		48'h022a_0000_0302, 48'h0281_0000_0200, 48'h0281_7f00_027f,
		48'h02f1_2a00_092a, 48'h0382_007f_067f, 48'h0382_0107_0707,
		48'h0382_0205_0805, 48'h0283_1f00_051f, 48'h01e3_0000_0f00,
		48'h0105_0000_0f00, 48'h02e1_e000_0f00};
	lcdcd_top i_dut (.CLK(CLK), .RST(RST), .TOK(TOK), .TOK_VALID(TOK_VALID),
		.TOK_READY(TOK_READY), .PTR_STEP(PTR_STEP), .SILICON_VERSION(SILICON_VERSION),
		.RAM_RDATA(RAM_RDATA), .RAM_REQ(RAM_REQ), .RAM_RE(RAM_RE), .RD_DATA(RD_DATA),
		.RD_VALID(RD_VALID), .CFG(CFG), .DISPLAY_ON(DISPLAY_ON),
		.DRIVERS_ON(DRIVERS_ON), .SLEEP(SLEEP));
	lcdcd_ram_model i_ram (.clk(CLK), .req(RAM_REQ), .re(RAM_RE), .rdata(RAM_RDATA));
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (RD_VALID === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
			rd_last <= RD_DATA;
		end
		if (TOK_VALID && TOK_READY === 1'b0)
			full_seen <= 1'b1;
	end
	// ==========
	// shared tasks
	task automatic chk(input string s, input logic [63:0] e, g);
		checks_done++;
		if (e !== g) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic send(input logic s, input logic [7:0] d);
		logic r;
		TOK <= '{s, d};
		TOK_VALID <= 1'b1;
		// ready is a flop: its mid-cycle value is what the next edge uses
		do begin
			@(negedge CLK);
			r = TOK_READY;
			@(posedge CLK);
		end while (r !== 1'b1);
	endtask
	task automatic cmd(input logic [7:0] k, c0, c1, c2);
		send(1'b0, c0);
		if (k > 1) send(1'b1, c1);
		if (k > 2) send(1'b1, c2);
		TOK_VALID <= 1'b0;
		repeat (6) @(posedge CLK);
	endtask
	task automatic at(input logic [7:0] p, c);
		cmd(1, 8'hb0 | p, 0, 0);
		cmd(2, 8'h04, c, 0);
	endtask
	function automatic logic [7:0] fld(input logic [7:0] x);
		case (x)
			8'h0: return 8'(CFG.bias_ratio_select);
			8'h1: return 8'(CFG.temp_coef_select);
			8'h2: return 8'(CFG.contrast_level);
			8'h3: return 8'(CFG.pump_config);
			8'h4: return 8'(CFG.panel_control);
			8'h5: return 8'(CFG.scan_clock_divider);
			8'h6: return 8'(CFG.line_width_clocks);
			8'h7: return 8'(CFG.isolation_front_clocks);
			8'h8: return 8'(CFG.isolation_end_clocks);
			default: return 8'(CFG.last_row_index);
		endcase
	endfunction
	task tally_and_finish;
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		mismatches++;
		tally_and_finish();
	end
	// ==========
	// main sequence
	initial begin
		RST = 1'b1;
		TOK = '0;
		TOK_VALID = 1'b0;
		PTR_STEP = 3'h0;
		SILICON_VERSION = 1'b1;
		full_seen = 1'b0;
		rd_cnt = 0;
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		chk("cfg", CFG, CFG_RST);
		chk("sleep", {DISPLAY_ON, SLEEP}, 2'h1);
		for (int k = 0; k < 4; k++) begin
			cmd(1, 8'h24 | 8'(k), 0, 0);
			cmd(1, 8'he8 | 8'(k), 0, 0);
			cmd(1, 8'h2c | 8'(k), 0, 0);
			cmd(1, 8'ha0 | 8'(k), 0, 0);
			chk("temp", fld(1), k);
			chk("bias", fld(0), k);
			chk("pump", fld(3), k + 4);
			chk("mclk", fld(4), k);
		end
		foreach (rows[i]) begin
			{n, b0, b1, b2, f, v} = rows[i];
			prev = CFG;
			cmd(n, b0, b1, b2);
			if (f == 8'hf) chk("quiet", CFG, prev);
			else chk("field", fld(f), v);
		end
		cmd(2, 8'hc9, 8'hbf, 0);
		chk("disp", DISPLAY_ON, 1'b0);
		cmd(2, 8'he1, 8'he2, 0);
		chk("cfg", CFG, CFG_RST);
		at(3, 8'h7e);
		for (int k = 0; k < 3; k++) cmd(2, 8'h01, 8'haa + 8'(k * 17), 0);
		chk("ram", i_ram.mem[3][126], 8'haa);
		chk("ram", i_ram.mem[3][127], 8'hcc);
		PTR_STEP <= 3'h1;
		at(7, 8'h7f);
		cmd(2, 8'h01, 8'h11, 0);
		cmd(2, 8'h01, 8'h22, 0);
		chk("ram", i_ram.mem[0][0], 8'h22);
		PTR_STEP <= 3'h5;
		at(0, 8'h7f);
		cmd(2, 8'h01, 8'h33, 0);
		cmd(2, 8'h01, 8'h44, 0);
		chk("ram", i_ram.mem[7][0], 8'h44);
		// column stepping down from 1 to 0, wrap off
		PTR_STEP <= 3'h2;
		at(2, 8'h01);
		cmd(2, 8'h01, 8'h66, 0);
		cmd(2, 8'h01, 8'h77, 0);
		chk("ram", i_ram.mem[2][1], 8'h66);
		chk("ram", i_ram.mem[2][0], 8'h77);
		// column stepping down with wrap, page up
		PTR_STEP <= 3'h3;
		at(4, 8'h00);
		cmd(2, 8'h01, 8'h88, 0);
		cmd(2, 8'h01, 8'h99, 0);
		chk("ram", i_ram.mem[4][0], 8'h88);
		chk("ram", i_ram.mem[5][127], 8'h99);
		PTR_STEP <= 3'h0;
		at(3, 8'h7e);
		cmd(2, 8'h02, 0, 0);
		chk("rd", rd_last, 8'haa);
		cmd(2, 8'h02, 0, 0);
		chk("rd", rd_last, 8'hcc);
		cmd(1, 8'ha6, 0, 0);
		at(1, 8'h05);
		cmd(2, 8'h01, 8'h5a, 0);
		chk("mirror", i_ram.mem[1][122], 8'h5a);
		cmd(2, 8'h03, 0, 0);
		chk("status", rd_last, 8'ha0);
		cmd(2, 8'hc9, 8'haf, 0);
		repeat (4) @(posedge CLK);
		chk("power", {DISPLAY_ON, DRIVERS_ON, SLEEP}, 3'h6);
		cmd(1, 8'haa, 0, 0);
		cmd(2, 8'h03, 0, 0);
		chk("status", rd_last, 8'hd0);
		cmd(2, 8'hc9, 8'hae, 0);
		chk("power", {DISPLAY_ON, DRIVERS_ON, SLEEP}, 3'h1);
		// reads stall the decoder, so a steady stream of them backs the queue up
		base = rd_cnt;
		for (int k = 0; k < 15; k++) begin
			send(1'b0, 8'h02);
			send(1'b1, 8'h00);
		end
		TOK_VALID <= 1'b0;
		repeat (40) @(posedge CLK);
		chk("full", full_seen, 1'b1);
		chk("reads", rd_cnt - base, 15);
		RST <= 1'b1;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		chk("cfg", CFG, CFG_RST);
		cmd(2, 8'h02, 0, 0);
		chk("rd", rd_last, 8'h22);
		tally_and_finish();
	end
endmodule
bind lcdcd_top lcdcd_checker i_chk (.CLK(CLK), .RST(RST), .TOK_VALID(TOK_VALID),
	.RAM_REQ(RAM_REQ), .RAM_RE(RAM_RE), .RD_VALID(RD_VALID), .CFG(CFG),
	.DISPLAY_ON(DISPLAY_ON), .DRIVERS_ON(DRIVERS_ON), .SLEEP(SLEEP));
`default_nettype wire
